// ==== bench/svuf_net_model.sv ====
// Network and rack side model: slave joins, transfer errors, unit restarts.
// Assumes the bench calls its tasks right after a rising edge.
`default_nettype none

module svuf_net_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [15:0] unit_restart_pulse_ff,
  output var  logic        slave_join_valid,
  output var  logic        slave_join_is_input,
  output var  logic [3:0]  slave_join_node,
  output var  logic        xfer_error_valid,
  output var  logic [3:0]  xfer_error_unit,
  output var  logic [15:0] unit_restart_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int          dly = 2;
  int          cnt;
  logic [15:0] pend;
  initial begin
    slave_join_valid = 1'b0;
    slave_join_is_input = 1'b0;
    slave_join_node = 4'h0;
    xfer_error_valid = 1'b0;
    xfer_error_unit = 4'h0;
  end
  // Restarted units report done after dly cycles
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 16'h0000;
      cnt <= 0;
      unit_restart_done <= 16'h0000;
    end else begin
      unit_restart_done <= 16'h0000;
      if (|unit_restart_pulse_ff) begin
        pend <= pend | unit_restart_pulse_ff;
        cnt <= dly;
      end else if (cnt > 1) cnt <= cnt - 1;
      else if (cnt == 1) begin
        unit_restart_done <= pend;
        pend <= 16'h0000;
        cnt <= 0;
      end
    end
  end
  task automatic slave_joins(input logic is_in, input logic [3:0] node);
    @(posedge hclk);
    slave_join_valid <= 1'b1;
    slave_join_is_input <= is_in;
    slave_join_node <= node;
    @(posedge hclk);
    slave_join_valid <= 1'b0;
    slave_join_node <= ~node;
  endtask
  task automatic xfer_err(input logic [3:0] unit);
    @(posedge hclk);
    xfer_error_valid <= 1'b1;
    xfer_error_unit <= unit;
    @(posedge hclk);
    xfer_error_valid <= 1'b0;
    xfer_error_unit <= ~unit;
  endtask
endmodule // svuf_net_model
`default_nettype wire

// ==== bench/svuf_props.sv ====
// Checker of the slave verify bank top module ports.
// Assumes one clock domain and the register map header on the include path.
`default_nettype none
`include "svuf_regs.vh"

module svuf_props #(
  parameter int N_UNITS  = 16,
  parameter int OWN_UNIT = 0
) (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic               hreadyout_ff,
  input wire logic               hresp_ff,
  input wire logic [N_UNITS-1:0] unit_remote_rack,
  input wire logic [N_UNITS-1:0] unit_restart_pulse_ff,
  input wire logic [N_UNITS-1:0] unit_refresh_en_ff,
  input wire logic               polling_en_ff,
  input wire logic [15:0]        mon_time_active_ff,
  input wire logic               irq_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********************
  // Cycles since a write to the restart word
  // ********************
  logic [7:0] wcnt_ff;
  wire        req_wr = hsel && hready && htrans[1] && hwrite &&
                       haddr[9:2] == `SVUF_IDX_RESTART_REQ;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wcnt_ff <= 8'hff;
    else if (req_wr) wcnt_ff <= 8'h00;
    else if (wcnt_ff != 8'hff) wcnt_ff <= wcnt_ff + 8'h01;
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ********************
  // Properties
  // ********************
  property p_ready;
    hreadyout_ff && !hresp_ff;
  endproperty
  a_ready: assert property (p_ready)
    else $error("slave not ready or bad response");
  property p_pulse_once;
    |unit_restart_pulse_ff |=>
      (unit_restart_pulse_ff & $past(unit_restart_pulse_ff)) == '0;
  endproperty
  a_pulse_once: assert property (p_pulse_once)
    else $error("restart pulse longer than one cycle");
  property p_pulse_cause;
    |unit_restart_pulse_ff |-> wcnt_ff <= 8'h06;
  endproperty
  a_pulse_cause: assert property (p_pulse_cause)
    else $error("restart pulse without a restart word write");
  property p_remote;
    1'b1 |=> (~unit_refresh_en_ff & $past(unit_remote_rack)) == '0;
  endproperty
  a_remote: assert property (p_remote)
    else $error("refresh stopped on a remote rack unit");
  property p_mon_load;
    !$stable(mon_time_active_ff) |->
      !$past(polling_en_ff) || !$past(polling_en_ff, 2);
  endproperty
  a_mon_load: assert property (p_mon_load)
    else $error("monitor time changed outside a load");
  property p_poll_cause;
    $fell(polling_en_ff) |-> wcnt_ff <= 8'h08;
  endproperty
  a_poll_cause: assert property (p_poll_cause)
    else $error("polling stopped without a restart");
  property p_poll_hold;
    $fell(polling_en_ff) |-> !polling_en_ff [*8];
  endproperty
  a_poll_hold: assert property (p_poll_hold)
    else $error("polling resumed too early");
  property p_poll_back;
    $fell(polling_en_ff) |-> ##[8:40] polling_en_ff;
  endproperty
  a_poll_back: assert property (p_poll_back)
    else $error("polling did not resume after restart");
  property p_own_restart;
    $rose(unit_restart_pulse_ff[OWN_UNIT]) |-> ##[0:3] !polling_en_ff;
  endproperty
  a_own_restart: assert property (p_own_restart)
    else $error("own restart did not stop polling");
  c_pulse: cover property (|unit_restart_pulse_ff);
  c_poll: cover property ($fell(polling_en_ff));
  c_irq: cover property ($rose(irq_ff));
endmodule // svuf_props

bind svuf_top svuf_props #(.N_UNITS(N_UNITS), .OWN_UNIT(OWN_UNIT)) u_props (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout_ff, .hresp_ff, .unit_remote_rack, .unit_restart_pulse_ff,
  .unit_refresh_en_ff, .polling_en_ff, .mon_time_active_ff, .irq_ff);
`default_nettype wire

// ==== bench/svuf_tb.sv ====
// Self-checking bench of the slave verify bank over AHB-Lite.
// Assumes zero wait slave and the register map header on the include path.
`default_nettype none
`include "svuf_regs.vh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        hclk, hresetn, hsel, hwrite, reg_enable_switch;
  logic [31:0] haddr, hwdata, hrdata_ff, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire         hreadyout_ff;
  logic        hresp_ff, bus_unit_dup, basic_io_word_dup, irq_ff;
  logic        slave_join_valid, slave_join_is_input, xfer_error_valid;
  logic [3:0]  slave_join_node, xfer_error_unit;
  logic [15:0] unit_number_dup, unit_restart_done, unit_remote_rack;
  logic [15:0] unit_restart_pulse_ff, unit_refresh_en_ff, mon_time_active_ff;
  logic        polling_en_ff;
  int          n_errors, n_compared, cyc;
  logic [7:0]  rst_idx [10] = '{`SVUF_IDX_OUT_UNREG, `SVUF_IDX_IN_UNREG,
    `SVUF_IDX_RESTARTING, `SVUF_IDX_DUP_FLAGS, `SVUF_IDX_ERR_FLAGS,
    `SVUF_IDX_UNIT_STAT, `SVUF_IDX_ERR_UNIT, `SVUF_IDX_RESTART_REQ,
    `SVUF_IDX_REFRESH_DIS, 8'h3f};

  svuf_top dut (.hready(hreadyout_ff), .*);
  svuf_net_model net (.*);

  always #2.5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop;
    end
  end
  // ********************
  // Bus and compare tasks
  // ********************
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    haddr <= {22'h000000, idx, 2'h0};
    hwrite <= wr;
    htrans <= `SVUF_HTRANS_NONSEQ;
    @(posedge hclk);
    while (hreadyout_ff !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout_ff !== 1'b1) @(posedge hclk);
    rd = hrdata_ff;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    bus(1'b1, idx, {16'h0000, d});
  endtask
  task automatic chk(input logic [7:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 32'h00000000);
    cmp(rd, {16'h0000, exp});
  endtask
  task automatic restart(input int u);
    wr(`SVUF_IDX_RESTART_REQ, 16'h0001 << u);
    wr(`SVUF_IDX_RESTART_REQ, 16'h0000);
  endtask
  task automatic own_restart;
    restart(0);
    while (polling_en_ff !== 1'b0) @(posedge hclk);
    while (polling_en_ff !== 1'b1) @(posedge hclk);
    @(posedge hclk);
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ********************
  // Scenarios
  // ********************
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    reg_enable_switch = 1'b0;
    unit_number_dup = 16'h0000;
    bus_unit_dup = 1'b0;
    basic_io_word_dup = 1'b0;
    unit_remote_rack = 16'h0000;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rst_idx[k]) chk(rst_idx[k], 16'h0000);
    chk(`SVUF_IDX_ACTIVE, 16'h0002);
    wr(`SVUF_IDX_OUT_TABLE, 16'h0005);
    wr(`SVUF_IDX_IN_TABLE, 16'h8000);
    wr(`SVUF_IDX_MON_TIME, 16'h1234);
    cmp(mon_time_active_ff, 32'h00000000);
    net.slave_joins(1'b0, 4'hd);
    chk(`SVUF_IDX_OUT_UNREG, 16'h0000);
    reg_enable_switch <= 1'b1;
    own_restart;
    cmp(mon_time_active_ff, 32'h00001234);
    chk(`SVUF_IDX_ACTIVE, 16'h0003);
    net.slave_joins(1'b0, 4'hd);
    net.slave_joins(1'b0, 4'h2);
    net.slave_joins(1'b1, 4'hf);
    net.slave_joins(1'b1, 4'h0);
    net.slave_joins(1'b0, 4'hd);
    chk(`SVUF_IDX_OUT_UNREG, 16'h2000);
    chk(`SVUF_IDX_IN_UNREG, 16'h0001);
    wr(`SVUF_IDX_IN_UNREG, 16'hffff);
    chk(`SVUF_IDX_IN_UNREG, 16'h0001);
    chk(`SVUF_IDX_IRQ_STAT, 16'h0013);
    wr(`SVUF_IDX_IRQ_EN, 16'h0001);
    repeat (2) @(posedge hclk);
    cmp(irq_ff, 32'h00000001);
    wr(`SVUF_IDX_IRQ_CLR, 16'h0001);
    chk(`SVUF_IDX_IRQ_STAT, 16'h0012);
    cmp(irq_ff, 32'h00000000);
    wr(`SVUF_IDX_IRQ_EN, 16'h0002);
    repeat (2) @(posedge hclk);
    cmp(irq_ff, 32'h00000001);
    wr(`SVUF_IDX_IRQ_EN, 16'h0000);
    repeat (2) @(posedge hclk);
    cmp(irq_ff, 32'h00000000);
    wr(`SVUF_IDX_MON_TIME, 16'h0042);
    chk(`SVUF_IDX_MON_TIME, 16'h0042);
    cmp(mon_time_active_ff, 32'h00001234);
    net.dly = 30;
    restart(5);
    while (unit_restart_pulse_ff[5] !== 1'b1) @(posedge hclk);
    chk(`SVUF_IDX_RESTARTING, 16'h0020);
    while (unit_restart_done[5] !== 1'b1) @(posedge hclk);
    @(posedge hclk);
    chk(`SVUF_IDX_RESTARTING, 16'h0000);
    own_restart;
    chk(`SVUF_IDX_OUT_UNREG, 16'h0000);
    chk(`SVUF_IDX_IN_UNREG, 16'h0000);
    unit_remote_rack <= 16'h0080;
    wr(`SVUF_IDX_REFRESH_DIS, 16'h00c0);
    chk(`SVUF_IDX_REFRESH_DIS, 16'h00c0);
    cmp(unit_refresh_en_ff, 32'h0000ffbf);
    bus_unit_dup <= 1'b1;
    @(posedge hclk);
    chk(`SVUF_IDX_UNIT_STAT, 16'h0001);
    chk(`SVUF_IDX_DUP_FLAGS, 16'h0000);
    unit_number_dup <= 16'h0408;
    @(posedge hclk);
    chk(`SVUF_IDX_DUP_FLAGS, 16'h0408);
    chk(`SVUF_IDX_UNIT_STAT, 16'h0003);
    chk(`SVUF_IDX_ERR_FLAGS, 16'h0408);
    chk(`SVUF_IDX_ERR_UNIT, 16'h0003);
    unit_number_dup <= 16'h0000;
    net.xfer_err(4'h9);
    chk(`SVUF_IDX_ERR_FLAGS, 16'h0608);
    chk(`SVUF_IDX_ERR_UNIT, 16'h0009);
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire

// ==== core/svuf_fall_detect.v ====
// Per-bit high-then-low detector on a software written control word.
// Assumes lvl is a register of the same clock domain.
`default_nettype none

module svuf_fall_detect #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] lvl,
  output reg  [W-1:0] fall_ff
);

  reg [W-1:0] prev_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= {W{1'b0}};
      fall_ff <= {W{1'b0}};
    end else begin
      prev_ff <= lvl;
      fall_ff <= prev_ff & ~lvl;
    end
  end

endmodule // svuf_fall_detect

`default_nettype wire

// ==== core/svuf_flag_word.v ====
// Sticky flag word: set bits stay set until a synchronous clear-all.
// Assumes set and clr are synchronous to clk; a set beats a clear.
`default_nettype none

module svuf_flag_word #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         clr,
  input  wire [W-1:0] set,
  output reg  [W-1:0] flags_ff
);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= {W{1'b0}};
    end else begin
      flags_ff <= (clr ? {W{1'b0}} : flags_ff) | set;
    end
  end

endmodule // svuf_flag_word

`default_nettype wire

// ==== core/svuf_regs.vh ====
// Register map, field positions and timing counts of the slave verify bank.
// Assumes an AHB-Lite word bus; each index is a word, byte address = 4*index.
`ifndef SVUF_REGS_VH
`define SVUF_REGS_VH

// ***************************************************************
// Register indexes
// ***************************************************************
`define SVUF_IDX_OUT_UNREG   8'h08
`define SVUF_IDX_IN_UNREG    8'h09
`define SVUF_IDX_RESTARTING  8'h10
`define SVUF_IDX_DUP_FLAGS   8'h11
`define SVUF_IDX_ERR_FLAGS   8'h12
`define SVUF_IDX_UNIT_STAT   8'h13
`define SVUF_IDX_ERR_UNIT    8'h14
`define SVUF_IDX_RESTART_REQ 8'h15
`define SVUF_IDX_REFRESH_DIS 8'h16
`define SVUF_IDX_OUT_TABLE   8'h20
`define SVUF_IDX_IN_TABLE    8'h21
`define SVUF_IDX_MON_TIME    8'h22
`define SVUF_IDX_ACTIVE      8'h23
`define SVUF_IDX_IRQ_STAT    8'h30
`define SVUF_IDX_IRQ_EN      8'h31
`define SVUF_IDX_IRQ_CLR     8'h32

// ***************************************************************
// Fields and reset values
// ***************************************************************
`define SVUF_IDX_MSB         9
`define SVUF_IDX_LSB         2
`define SVUF_STAT_FATAL      0
`define SVUF_STAT_SPECIAL    1
`define SVUF_ACT_REG_EN      0
`define SVUF_ACT_POLLING     1
`define SVUF_IRQ_OUT_UNREG   0
`define SVUF_IRQ_IN_UNREG    1
`define SVUF_IRQ_FATAL       2
`define SVUF_IRQ_SPECIAL     3
`define SVUF_IRQ_RESTARTED   4
`define SVUF_IRQ_W           5
`define SVUF_RST_WORD        16'h0000
`define SVUF_RST_IRQ         5'h00
`define SVUF_RST_UNIT        4'h0
`define SVUF_HTRANS_NONSEQ   2'h2
`define SVUF_HTRANS_SEQ      2'h3

// ***************************************************************
// Timing
// ***************************************************************
`define SVUF_RESTART_CYC     8'h10

`endif

// ==== core/svuf_top.v ====
// Slave verify and unit flag register bank with AHB-Lite slave port.
// Assumes one clock, hready tied to this slave's hreadyout, inputs sync.
//
// Function
// [RL1] An output slave joining while not in the output table sets its bit.
// [RL2] Output word bits 0..15 map to output node numbers of equal index.
// [RL3] An unregistered input slave sets its bit in the input word 0..15.
// [RL4] Unregistered bits hold until power-up or restart, not on rejoin.
// [RL5] Tables and monitor time take effect only at power-up or restart.
// [RL6] The operator sets tables with registration off, then enables it.
// [RL7] Tables may be written while enabled, at the risk of false errors.
// [RL8] One restarting flag per unit number stays set while it restarts.
// [RL9] The fatal duplicate flag sets on any shared number or word.
// [RL10] The unit error flag sets on duplication or transfer error and logs.
// [RL11] Per-unit duplicate bits set only while the fatal flag is set.
// [RL12] Per-unit error bits set for duplicates or transfer errors.
// [RL13] A restart bit driven high then low restarts that unit.
// [RL14] A refresh-disable bit stops refresh except on remote racks.
// [RL15] Restart clears unregistered bits before polling and reloads tables.
//
// Added by the designer: register access over AHB-Lite.
`default_nettype none
`include "svuf_regs.vh"

module svuf_top #(
  parameter N_NODES   = 16,
  parameter N_UNITS   = 16,
  parameter OWN_UNIT  = 0,
  parameter UNIT_W    = 4
) (
  input  wire                hclk,
  input  wire                hresetn,
  input  wire                hsel,
  input  wire [31:0]         haddr,
  input  wire [1:0]          htrans,
  input  wire                hwrite,
  input  wire [2:0]          hsize,
  input  wire [31:0]         hwdata,
  input  wire                hready,
  output reg  [31:0]         hrdata_ff,
  output reg                 hreadyout_ff,
  output reg                 hresp_ff,
  input  wire                reg_enable_switch,
  input  wire                slave_join_valid,
  input  wire                slave_join_is_input,
  input  wire [UNIT_W-1:0]   slave_join_node,
  input  wire [N_UNITS-1:0]  unit_number_dup,
  input  wire                bus_unit_dup,
  input  wire                basic_io_word_dup,
  input  wire                xfer_error_valid,
  input  wire [UNIT_W-1:0]   xfer_error_unit,
  input  wire [N_UNITS-1:0]  unit_restart_done,
  input  wire [N_UNITS-1:0]  unit_remote_rack,
  output reg  [N_UNITS-1:0]  unit_restart_pulse_ff,
  output reg  [N_UNITS-1:0]  unit_refresh_en_ff,
  output reg                 polling_en_ff,
  output reg  [15:0]         mon_time_active_ff,
  output reg                 irq_ff
);

  // ***************************************************************
  // States
  // ***************************************************************
  localparam ST_LOAD    = 3'b001;
  localparam ST_RUN     = 3'b010;
  localparam ST_RESTART = 3'b100;

  reg [2:0]          state_ff, nxt_state;
  reg [7:0]          rst_cnt_ff, nxt_rst_cnt;

  // ***************************************************************
  // Software registers
  // ***************************************************************
  reg [15:0]         restart_req_ff, refresh_dis_ff;
  reg [15:0]         out_table_ff, in_table_ff, mon_time_ff;
  reg [15:0]         out_table_act_ff, in_table_act_ff;
  reg                reg_en_act_ff;
  reg [`SVUF_IRQ_W-1:0] irq_en_ff;
  reg [N_UNITS-1:0]  restarting_ff;
  reg                fatal_dup_ff, special_err_ff;
  reg [UNIT_W-1:0]   err_unit_ff;

  // ***************************************************************
  // Bus address phase capture
  // ***************************************************************
  reg                wr_pend_ff;
  reg [7:0]          wr_idx_ff;
  wire               xfer_ok;
  wire [7:0]         a_idx;

  assign xfer_ok = hsel && hready &&
                   (htrans == `SVUF_HTRANS_NONSEQ ||
                    htrans == `SVUF_HTRANS_SEQ);
  assign a_idx   = haddr[`SVUF_IDX_MSB:`SVUF_IDX_LSB];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff   <= 1'b0;
      wr_idx_ff    <= 8'h00;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      wr_pend_ff   <= xfer_ok && hwrite;
      wr_idx_ff    <= a_idx;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
  end

  // ***************************************************************
  // Sticky flag words
  // ***************************************************************
  wire               load_phase, node_ok, fatal_now;
  wire [N_NODES-1:0] node_hot, out_unreg_set, in_unreg_set;
  wire [N_NODES-1:0] out_unreg, in_unreg;
  wire [N_UNITS-1:0] dup_set, err_set, dup_flags, err_flags, xfer_hot;

  assign load_phase = (state_ff == ST_LOAD);
  assign node_ok    = slave_join_valid && reg_en_act_ff && polling_en_ff;
  assign node_hot   = {{(N_NODES-1){1'b0}}, 1'b1} << slave_join_node;
  assign out_unreg_set = (node_ok && !slave_join_is_input) ?
                         (node_hot & ~out_table_act_ff) :
                         {N_NODES{1'b0}}; // RL1 RL2
  assign in_unreg_set  = (node_ok && slave_join_is_input) ?
                         (node_hot & ~in_table_act_ff) :
                         {N_NODES{1'b0}}; // RL3
  assign xfer_hot  = xfer_error_valid ?
                     ({{(N_UNITS-1){1'b0}}, 1'b1} << xfer_error_unit) :
                     {N_UNITS{1'b0}};
  assign fatal_now = (|unit_number_dup) | bus_unit_dup |
                     basic_io_word_dup; // RL9
  assign dup_set   = fatal_now ? unit_number_dup :
                     {N_UNITS{1'b0}}; // RL11
  assign err_set   = unit_number_dup | xfer_hot; // RL12

  // Cleared only by the load phase of power-up or restart
  svuf_flag_word #(.W(2*N_NODES)) u_unreg (
    .clk      (hclk),
    .rst_n    (hresetn),
    .clr      (load_phase), // RL4 RL15
    .set      ({in_unreg_set, out_unreg_set}),
    .flags_ff ({in_unreg, out_unreg})
  );

  svuf_flag_word #(.W(2*N_UNITS)) u_dup_err (
    .clk      (hclk),
    .rst_n    (hresetn),
    .clr      (1'b0),
    .set      ({err_set, dup_set}),
    .flags_ff ({err_flags, dup_flags})
  );

  // ***************************************************************
  // Restart bit edge detection
  // ***************************************************************
  wire [N_UNITS-1:0] restart_fall;

  svuf_fall_detect #(.W(N_UNITS)) u_fall (
    .clk     (hclk),
    .rst_n   (hresetn),
    .lvl     (restart_req_ff[N_UNITS-1:0]),
    .fall_ff (restart_fall)
  );

  wire own_restart = restart_fall[OWN_UNIT]; // RL13

  // ***************************************************************
  // Power-up and restart sequence
  // ***************************************************************
  always @* begin
    nxt_state   = state_ff;
    nxt_rst_cnt = rst_cnt_ff;
    case (state_ff)
      ST_LOAD: nxt_state = ST_RUN;
      ST_RUN: begin
        if (own_restart) begin
          nxt_state   = ST_RESTART;
          nxt_rst_cnt = `SVUF_RESTART_CYC;
        end
      end
      ST_RESTART: begin
        nxt_rst_cnt = rst_cnt_ff - 8'h01;
        if (rst_cnt_ff == 8'h01) begin
          nxt_state = ST_LOAD;
        end
      end
      default: nxt_state = ST_LOAD;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff      <= ST_LOAD;
      rst_cnt_ff    <= 8'h00;
      polling_en_ff <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      rst_cnt_ff    <= nxt_rst_cnt;
      polling_en_ff <= (nxt_state == ST_RUN); // RL15
    end
  end

  // Settings are sampled here and nowhere else
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_table_act_ff   <= `SVUF_RST_WORD;
      in_table_act_ff    <= `SVUF_RST_WORD;
      mon_time_active_ff <= `SVUF_RST_WORD;
      reg_en_act_ff      <= 1'b0;
    end else if (load_phase) begin
      out_table_act_ff   <= out_table_ff; // RL5 RL15
      in_table_act_ff    <= in_table_ff; // RL5 RL15
      mon_time_active_ff <= mon_time_ff; // RL5
      reg_en_act_ff      <= reg_enable_switch; // RL6
    end
  end

  // ***************************************************************
  // Unit restart, duplicate and error status
  // ***************************************************************
  wire [N_UNITS-1:0] own_bit, ext_done;

  assign own_bit  = {{(N_UNITS-1){1'b0}}, 1'b1} << OWN_UNIT;
  assign ext_done = (unit_restart_done & ~own_bit) |
                    (load_phase ? own_bit : {N_UNITS{1'b0}}); // RL8

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      restarting_ff         <= {N_UNITS{1'b0}};
      unit_restart_pulse_ff <= {N_UNITS{1'b0}};
    end else begin
      unit_restart_pulse_ff <= restart_fall; // RL13
      restarting_ff <= (restarting_ff & ~ext_done) |
                       restart_fall; // RL8
    end
  end

  integer i;
  reg [UNIT_W-1:0] dup_unit;
  always @* begin
    dup_unit = `SVUF_RST_UNIT;
    for (i = N_UNITS - 1; i >= 0; i = i - 1) begin
      if (unit_number_dup[i]) begin
        dup_unit = i[UNIT_W-1:0];
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fatal_dup_ff   <= 1'b0;
      special_err_ff <= 1'b0;
      err_unit_ff    <= `SVUF_RST_UNIT;
    end else begin
      if (fatal_now) begin
        fatal_dup_ff <= 1'b1; // RL9
      end
      if ((|unit_number_dup) || xfer_error_valid) begin
        special_err_ff <= 1'b1; // RL10
        err_unit_ff    <= xfer_error_valid ? xfer_error_unit :
                          dup_unit; // RL10
      end
    end
  end

  // ***************************************************************
  // Refresh control
  // ***************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_refresh_en_ff <= {N_UNITS{1'b1}};
    end else begin
      unit_refresh_en_ff <= ~refresh_dis_ff[N_UNITS-1:0] |
                            unit_remote_rack; // RL14
    end
  end

  // ***************************************************************
  // Software writable registers
  // ***************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      restart_req_ff <= `SVUF_RST_WORD;
      refresh_dis_ff <= `SVUF_RST_WORD;
      out_table_ff   <= `SVUF_RST_WORD;
      in_table_ff    <= `SVUF_RST_WORD;
      mon_time_ff    <= `SVUF_RST_WORD;
      irq_en_ff      <= `SVUF_RST_IRQ;
    end else if (wr_pend_ff) begin
      case (wr_idx_ff)
        `SVUF_IDX_RESTART_REQ: restart_req_ff <= hwdata[15:0];
        `SVUF_IDX_REFRESH_DIS: refresh_dis_ff <= hwdata[15:0];
        `SVUF_IDX_OUT_TABLE:   out_table_ff   <= hwdata[15:0]; // RL7
        `SVUF_IDX_IN_TABLE:    in_table_ff    <= hwdata[15:0]; // RL7
        `SVUF_IDX_MON_TIME:    mon_time_ff    <= hwdata[15:0];
        `SVUF_IDX_IRQ_EN:      irq_en_ff      <= hwdata[`SVUF_IRQ_W-1:0];
        default:               irq_en_ff      <= irq_en_ff;
      endcase
    end
  end

  // ***************************************************************
  // Interrupt status, clear and output
  // ***************************************************************
  reg  [`SVUF_IRQ_W-1:0] irq_stat_ff;
  wire [`SVUF_IRQ_W-1:0] irq_set, irq_clr;

  assign irq_set[`SVUF_IRQ_OUT_UNREG] = |out_unreg_set;
  assign irq_set[`SVUF_IRQ_IN_UNREG]  = |in_unreg_set;
  assign irq_set[`SVUF_IRQ_FATAL]     = fatal_now;
  assign irq_set[`SVUF_IRQ_SPECIAL]   = (|unit_number_dup) |
                                        xfer_error_valid;
  assign irq_set[`SVUF_IRQ_RESTARTED] = load_phase;
  assign irq_clr = (wr_pend_ff && wr_idx_ff == `SVUF_IDX_IRQ_CLR) ?
                   hwdata[`SVUF_IRQ_W-1:0] : `SVUF_RST_IRQ;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_ff <= `SVUF_RST_IRQ;
      irq_ff      <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
      irq_ff      <= |(((irq_stat_ff & ~irq_clr) | irq_set) &
                       irq_en_ff);
    end
  end

  // ***************************************************************
  // Read data, registered in the address phase
  // ***************************************************************
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (a_idx)
      `SVUF_IDX_OUT_UNREG:   rd_mux[N_NODES-1:0] = out_unreg; // RL2
      `SVUF_IDX_IN_UNREG:    rd_mux[N_NODES-1:0] = in_unreg; // RL3
      `SVUF_IDX_RESTARTING:  rd_mux[N_UNITS-1:0] = restarting_ff;
      `SVUF_IDX_DUP_FLAGS:   rd_mux[N_UNITS-1:0] = dup_flags;
      `SVUF_IDX_ERR_FLAGS:   rd_mux[N_UNITS-1:0] = err_flags;
      `SVUF_IDX_UNIT_STAT: begin
        rd_mux[`SVUF_STAT_FATAL]   = fatal_dup_ff;
        rd_mux[`SVUF_STAT_SPECIAL] = special_err_ff;
      end
      `SVUF_IDX_ERR_UNIT:    rd_mux[UNIT_W-1:0]  = err_unit_ff;
      `SVUF_IDX_RESTART_REQ: rd_mux[15:0]        = restart_req_ff;
      `SVUF_IDX_REFRESH_DIS: rd_mux[15:0]        = refresh_dis_ff;
      `SVUF_IDX_OUT_TABLE:   rd_mux[15:0]        = out_table_ff;
      `SVUF_IDX_IN_TABLE:    rd_mux[15:0]        = in_table_ff;
      `SVUF_IDX_MON_TIME:    rd_mux[15:0]        = mon_time_ff;
      `SVUF_IDX_ACTIVE: begin
        rd_mux[`SVUF_ACT_REG_EN]  = reg_en_act_ff;
        rd_mux[`SVUF_ACT_POLLING] = polling_en_ff;
      end
      `SVUF_IDX_IRQ_STAT: rd_mux[`SVUF_IRQ_W-1:0] = irq_stat_ff;
      `SVUF_IDX_IRQ_EN:   rd_mux[`SVUF_IRQ_W-1:0] = irq_en_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (xfer_ok && !hwrite) begin
      hrdata_ff <= rd_mux;
    end
  end

endmodule // svuf_top

`default_nettype wire
